// [otp_host.sv]
`timescale 1ns/1ps
`include "otp_host_consts.svh"

// Function
// - Program: select low, gate high, strobe low, supply raised; host drives data.
// - Identification: select, gate low, line nine at high voltage, lines 1-16 low.
// - Data valid within 20 or 30 ns of gate falling.
// - Gate may fall late; address access limit still governs.
// - Program strobe low pulse lasts 95 to 105 microseconds.
// - Up to ten pulse-verify attempts per byte, then declare failure.
module otp_host
#(
  parameter int PULSE_CYC = (`PULSE_NOM_NS / `CLK_PERIOD_NS)
)
(
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire otp_host_pkg::cmd_t  cmd,
  output logic                     rsp_valid,
  output otp_host_pkg::rsp_t       rsp,
  output otp_host_pkg::pins_t      pins,
  output logic [`DATA_W-1:0]       data_out,
  output logic                     data_oe_n,
  input  wire logic [`DATA_W-1:0]  data_in
);

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int ACC_CYC   = (`ADDR_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FLT_CYC   = (`FLOAT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int SETUP_CYC = (`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int HOLD_CYC  = (`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int CNT_W     = 16;

  typedef enum logic [2:0] {
    S_IDLE,
    S_READ,
    S_SETUP,
    S_PULSE,
    S_VGAP,
    S_VERIFY,
    S_FLOAT
  } state_t;

  state_t                   state_q, state_d;
  logic [CNT_W-1:0]         cnt_q, cnt_d;
  logic [3:0]               tries_q, tries_d;
  otp_host_pkg::cmd_t       cur_q, cur_d;
  otp_host_pkg::pins_t      pins_q, pins_d;
  logic                     oe_n_q, oe_n_d;
  otp_host_pkg::rsp_t       rsp_q, rsp_d;
  logic                     rv_q, rv_d;

  // Wait count as counter width
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  // Idle pin set: standby, supply low, outputs floated
  function automatic otp_host_pkg::pins_t idle_pins();
    otp_host_pkg::pins_t p;
    p = '0;
    p.select_n         = 1'b1;
    p.gate_n           = 1'b1;
    p.program_strobe_n = 1'b1;
    idle_pins = p;
  endfunction

  assign cmd_ready = (state_q == S_IDLE);
  assign pins      = pins_q;
  assign data_oe_n = oe_n_q;
  assign data_out  = cur_q.data;
  assign rsp       = rsp_q;
  assign rsp_valid = rv_q;

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    tries_d = tries_q;
    cur_d   = cur_q;
    pins_d  = pins_q;
    oe_n_d  = oe_n_q;
    rsp_d   = rsp_q;
    rv_d    = 1'b0;
    if (cnt_q != '0)
    begin
      cnt_d = cnt_q - 1'b1;
    end
    case (state_q)
      S_IDLE:
      begin
        if (cmd_valid)
        begin
          cur_d   = cmd;
          tries_d = '0;
          pins_d  = idle_pins();
          pins_d.byte_address_bus = cmd.addr;
          case (cmd.kind)
            otp_host_pkg::CMD_ID:
            begin
              // Only line zero follows request; others low, line nine high volts
              pins_d.byte_address_bus = '0;
              pins_d.byte_address_bus[`ID_SEL_BIT] = cmd.addr[`ID_SEL_BIT];
              pins_d.identification_voltage = 1'b1;
              pins_d.select_n = 1'b0;
              pins_d.gate_n   = 1'b0;
              cnt_d   = cyc(ACC_CYC);
              state_d = S_READ;
            end
            otp_host_pkg::CMD_PROG:
            begin
              pins_d.prog_supply_raise = 1'b1;
              pins_d.select_n = 1'b0;
              oe_n_d  = 1'b0;
              cnt_d   = cyc(SETUP_CYC);
              state_d = S_SETUP;
            end
            default:
            begin
              pins_d.select_n = 1'b0;
              pins_d.gate_n   = 1'b0;
              cnt_d   = cyc(ACC_CYC);
              state_d = S_READ;
            end
          endcase
        end
      end
      S_READ:
      begin
        if (cnt_q == '0)
        begin
          rsp_d.data = data_in;
          rsp_d.fail = 1'b0;
          rv_d       = 1'b1;
          pins_d.gate_n   = 1'b1;
          pins_d.select_n = 1'b1;
          cnt_d   = cyc(FLT_CYC);
          state_d = S_FLOAT;
        end
      end
      S_SETUP:
      begin
        // Drive data only once the memory has floated its outputs
        if (cnt_q <= cyc(SETUP_CYC))
        begin
          oe_n_d = 1'b0;
        end
        if (cnt_q == '0)
        begin
          pins_d.program_strobe_n = 1'b0;
          cnt_d   = cyc(PULSE_CYC - 1); // Low for exactly PULSE_CYC cycles
          state_d = S_PULSE;
        end
      end
      S_PULSE:
      begin
        if (cnt_q == '0)
        begin
          pins_d.program_strobe_n = 1'b1;
          tries_d = tries_q + 1'b1;
          cnt_d   = cyc(SETUP_CYC);
          state_d = S_VGAP;
        end
      end
      S_VGAP:
      begin
        if (cnt_q == '0)
        begin
          oe_n_d  = 1'b1; // Release data on the same edge the gate opens
          pins_d.gate_n = 1'b0;
          cnt_d   = cyc(ACC_CYC);
          state_d = S_VERIFY;
        end
      end
      S_VERIFY:
      begin
        if (cnt_q == '0)
        begin
          pins_d.gate_n = 1'b1;
          if (data_in == cur_q.data || tries_q == 4'(`MAX_TRIES))
          begin
            rsp_d.data = data_in;
            rsp_d.fail = (data_in != cur_q.data);
            rv_d       = 1'b1;
            pins_d.select_n = 1'b1;
            pins_d.prog_supply_raise = 1'b0;
            cnt_d   = cyc(FLT_CYC);
            state_d = S_FLOAT;
          end
          else
          begin
            cnt_d   = cyc(FLT_CYC + SETUP_CYC);
            state_d = S_SETUP;
          end
        end
        else if (state_q == S_VERIFY && cnt_q == cyc(1))
        begin
          oe_n_d = 1'b1;
        end
      end
      S_FLOAT:
      begin
        if (cnt_q == '0)
        begin
          pins_d  = idle_pins();
          pins_d.byte_address_bus = cur_q.addr;
          cnt_d   = cyc(HOLD_CYC);
          state_d = S_IDLE;
        end
      end
      default:
      begin
        state_d = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
      tries_q <= '0;
      cur_q   <= '0;
      pins_q  <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, '0}; // Standby, strobe high
      oe_n_q  <= 1'b1;
      rsp_q   <= '0;
      rv_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      tries_q <= tries_d;
      cur_q   <= cur_d;
      pins_q  <= pins_d;
      oe_n_q  <= oe_n_d;
      rsp_q   <= rsp_d;
      rv_q    <= rv_d;
    end
  end

endmodule // otp_host

// [otp_host_chk.sv]
`timescale 1ns/1ps
// ----------------------------
// Pin checker
// ----------------------------
module otp_host_chk #(
  parameter int PULSE_CYC = 20
)
(
  input logic                sys_clk,
  input logic                rstn,
  input logic                cmd_valid,
  input logic                cmd_ready,
  input otp_host_pkg::cmd_t  cmd,
  input logic                rsp_valid,
  input otp_host_pkg::rsp_t  rsp,
  input otp_host_pkg::pins_t pins,
  input logic [7:0]          data_out,
  input logic                data_oe_n,
  input logic [7:0]          data_in
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  int lo_q;
  int lo_d;
  // Strobe low length
  always_comb lo_d = pins.program_strobe_n ? 0 : lo_q + 1;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      lo_q <= 0;
    else
      lo_q <= lo_d;
  sequence take_rd;
    cmd_valid && cmd_ready && cmd.kind != otp_host_pkg::CMD_PROG;
  endsequence
  a_drive_no_clash: assert property (!data_oe_n |-> pins.gate_n && !pins.select_n)
    else $error("host drives with gate low");
  a_float_before_drive: assert property (!data_oe_n |-> $past(pins.gate_n, 1)
    && $past(pins.gate_n, 2) && $past(pins.gate_n, 3))
    else $error("host drives before memory floats");
  a_strobe_supply: assert property (!pins.program_strobe_n |-> pins.prog_supply_raise)
    else $error("strobe without supply");
  a_pulse_width: assert property ($rose(pins.program_strobe_n) |-> lo_q == PULSE_CYC)
    else $error("pulse width");
  a_id_lines_low: assert property (pins.identification_voltage
    |-> pins.byte_address_bus[16:1] == 16'h0000)
    else $error("id address high");
  a_read_answer: assert property (take_rd |-> ##[9:10] rsp_valid)
    else $error("read answer late");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer too long");
  a_gate_access: assert property ($fell(pins.gate_n) |-> !pins.gate_n [*7])
    else $error("gate too short");
  a_float_wait: assert property ($rose(pins.select_n) |-> !cmd_ready [*3])
    else $error("ready before float");
  a_addr_steady: assert property (!pins.gate_n |=> $stable(pins.byte_address_bus)
    || pins.gate_n)
    else $error("address moved");
endmodule // otp_host_chk

// [otp_host_consts.svh]
`ifndef OTP_HOST_CONSTS_SVH
`define OTP_HOST_CONSTS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define ADDR_W          17
`define DATA_W          8
`define ID_SEL_BIT      0
`define ID_HI_LSB       1

// ----------------------------------------------------------------
// Timing in ns (slow grade figures, safe for both grades)
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define ADDR_ACCESS_NS  70
`define GATE_ACCESS_NS  30
`define FLOAT_NS        25
`define HOLD_NS         7
`define SETUP_NS        2000
`define PULSE_NOM_NS    100000
`define MAX_TRIES       10

`endif

// [otp_host_pkg.sv]
package otp_host_pkg;

  // ----------------------------------------------------------------
  // Host command kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_ID,
    CMD_PROG
  } cmd_kind_t;

  typedef struct packed {
    cmd_kind_t   kind;
    logic [16:0] addr;
    logic [7:0]  data;
  } cmd_t;

  typedef struct packed {
    logic [7:0] data;
    logic       fail;
  } rsp_t;

  // Pins driven towards the memory
  typedef struct packed {
    logic        select_n;
    logic        gate_n;
    logic        program_strobe_n;
    logic        prog_supply_raise;
    logic        identification_voltage;
    logic [16:0] byte_address_bus;
  } pins_t;

endpackage

// [otp_mem_model.sv]
`timescale 1ns/1ps
// ----------------------------
// Memory seen from its pins
// ----------------------------
module otp_mem_model #(
  parameter logic [7:0] ID_MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] ID_TYPE  = 8'hc3, // Arbitrary value
  parameter int         ACC_NS   = 60
)
(
  input  otp_host_pkg::pins_t pins,
  input  logic [7:0]          data_out,
  output logic [7:0]          data_in
);
  logic [7:0] mem [int];
  logic [7:0] rd;
  int         a;
  // Stored byte or id byte
  always @*
  begin
    a = int'(pins.byte_address_bus);
    rd = mem.exists(a) ? mem[a] : 8'hff;
    if (pins.identification_voltage)
      rd = pins.byte_address_bus[0] ? ID_TYPE : ID_MAKER;
  end
  // Drive when selected and gated, else inverse
  assign #(ACC_NS) data_in = (!pins.select_n && !pins.gate_n) ? rd : ~rd;
  // Clear bits on strobe fall
  always @(negedge pins.program_strobe_n)
    if (!pins.select_n && pins.gate_n && pins.prog_supply_raise)
    begin
      mem[a] = rd & data_out;
      rd = mem[a];
    end
endmodule // otp_mem_model

// [otp_rom_byte_port_test.sv]
`timescale 1ns/1ps
`include "otp_host_consts.svh"
// ----------------------------
// Bench top
// ----------------------------
module otp_rom_byte_port_test;
  localparam int PULSE_CYC = 20;
  localparam logic [7:0] MK = 8'h5a;
  localparam logic [7:0] TY = 8'hc3;
  logic sys_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0;
  logic cmd_ready, rsp_valid, data_oe_n;
  logic [7:0] data_out, data_in;
  otp_host_pkg::cmd_t cmd = '0;
  otp_host_pkg::rsp_t rsp;
  otp_host_pkg::pins_t pins;
  logic [7:0] ref_mem [int];
  int miscompares = 0, n_compared = 0;
  int n_pulses = 0;
  // Clock
  always #5 sys_clk = ~sys_clk;
  // Program pulses seen at the memory
  always @(negedge pins.program_strobe_n) n_pulses++;
  otp_host #(.PULSE_CYC(PULSE_CYC)) u_otp_host (.sys_clk(sys_clk), .rstn(rstn),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp(rsp), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in));
  otp_mem_model #(.ID_MAKER(MK), .ID_TYPE(TY), .ACC_NS(`ADDR_ACCESS_NS)) u_otp_mem_model (
    .pins(pins),
    .data_out(data_out), .data_in(data_in));
  function automatic logic [7:0] rd(input int a);
    return ref_mem.exists(a) ? ref_mem[a] : 8'hff;
  endfunction
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One request held until taken, then its answer
  task automatic run(input otp_host_pkg::cmd_kind_t k, input logic [16:0] a,
                     input logic [7:0] d, output otp_host_pkg::rsp_t r);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd <= '{k, a, d};
    do @(negedge sys_clk); while (!cmd_ready);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    do @(negedge sys_clk); while (rsp_valid !== 1'b1 && ++n < 9000);
    if (rsp_valid !== 1'b1)
    begin
      miscompares++; // Answer never came
      final_report();
    end
    else
    begin
      r = rsp;
      @(posedge sys_clk);
    end
  endtask
  // Main sequence
  initial
  begin
    otp_host_pkg::rsp_t r;
    logic [16:0] a;
    logic [7:0] d, e;
    int k;
    void'($urandom(32'h20f2562d));
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
    begin
      a = 17'($urandom);
      run(otp_host_pkg::CMD_READ, a, 8'h00, r);
      check(r.data, rd(a));
      for (int p = 0; p < 2; p++)
      begin
        d = 8'($urandom);
        e = rd(a) & d;
        k = n_pulses;
        run(otp_host_pkg::CMD_PROG, a, d, r);
        check(r.fail, e != d);
        check(r.data, e);
        check(9'(n_pulses - k), 9'((e != d) ? `MAX_TRIES : 1));
        ref_mem[a] = e;
      end
      run(otp_host_pkg::CMD_READ, a, 8'h00, r);
      check(r.data, rd(a));
    end
    $display("program test done");
    for (int j = 0; j < 2; j++)
    begin
      run(otp_host_pkg::CMD_ID, {16'($urandom), j[0]}, 8'h00, r);
      check(r.data, j ? TY : MK);
    end
    $display("id test done");
    final_report();
  end
  // Watchdog
  initial
  begin
    #(600_000);
    miscompares++;
    final_report();
  end
endmodule // otp_rom_byte_port_test

bind otp_host otp_host_chk #(.PULSE_CYC(PULSE_CYC)) u_otp_host_chk (.sys_clk(sys_clk),
  .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
  .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .data_out(data_out),
  .data_oe_n(data_oe_n), .data_in(data_in));
